// [hdl/smb_consts.svh]
`ifndef SMB_CONSTS_SVH
`define SMB_CONSTS_SVH
// Slave address layout.
`define SMB_ADDR_HI 4'h5
`define SMB_ARA_ADDR 7'h0c
// Device configuration register and its alert-response disable bit.
`define SMB_CFG_OFS 8'h01
`define SMB_CFG_RST 8'h00
`define SMB_CFG_ARA_DIS 2
// Bit positions inside a nine-clock byte.
`define SMB_LAST_BIT 4'h7
`define SMB_ACK_BIT 4'h8
// Cycles after reset release before the strap code is taken.
`define SMB_STRAP_WAIT 4'h8
// Timing of the controller's serial clock.
`define SMB_CLK_NS 100
`define SMB_SCL_PERIOD_NS 10000
`define SMB_QTR_CYC ((`SMB_SCL_PERIOD_NS / 4 + `SMB_CLK_NS - 1) / `SMB_CLK_NS)
// Controller register map on the plain software port.
`define SMB_H_SLV 8'h00
`define SMB_H_PTR 8'h01
`define SMB_H_DATA 8'h02
`define SMB_H_CMD 8'h03
`define SMB_H_STAT 8'h04
`define SMB_H_RX 8'h05
// Controller operations written to the command register.
`define SMB_OP_PTR 2'h1
`define SMB_OP_WR 2'h2
`define SMB_OP_RD 2'h3
`endif

// [hdl/smb_pkg.sv]
package smb_pkg;
    typedef logic [7:0] smb_byte_t;
    typedef enum logic [2:0] {D_IDLE, D_ADDR, D_ACK, D_WR, D_TX, D_MACK, D_WAIT} smb_dev_state_t;
    typedef enum logic [1:0] {H_IDLE, H_START, H_BIT, H_STOP} smb_host_state_t;
endpackage : smb_pkg

// [hdl/smb_if.sv]
`timescale 1ns/10ps
`default_nettype none
interface smb_if;
    logic host_scl_o;
    logic host_scl_oe;
    logic host_sda_o;
    logic host_sda_oe;
    logic dev_sda_o;
    logic dev_sda_oe;
    logic dev_int_o;
    logic dev_int_oe;
    logic scl;
    logic sda;
    logic int_n;
    // Open-drain wires: a line is low while any enabled driver pulls it low.
    assign scl = host_scl_oe ? host_scl_o : 1'h1;
    assign sda = (host_sda_oe ? host_sda_o : 1'h1) & (dev_sda_oe ? dev_sda_o : 1'h1);
    assign int_n = dev_int_oe ? dev_int_o : 1'h1;
    modport dev (input scl, sda, int_n, output dev_sda_o, dev_sda_oe, dev_int_o, dev_int_oe);
    modport host (input scl, sda, int_n, output host_scl_o, host_scl_oe, host_sda_o, host_sda_oe);
endinterface : smb_if
`default_nettype wire

// [hdl/smb_dev.sv]
`timescale 1ns/10ps
`default_nettype none
`include "smb_consts.svh"
module smb_dev (
    input wire logic clk_i,                       // Device clock.
    input wire logic rstn_i,                      // Asynchronous reset, active low.
    smb_if.dev bus,                               // Serial bus pins.
    input wire logic [2:0] strap_i,               // Top three converter bits of the strap pin.
    input wire logic fault_i,                     // Fault condition present.
    input wire smb_pkg::smb_byte_t rd_data_i,     // Contents of the register at ptr_o.
    output logic [7:0] ptr_o,                     // Register pointer.
    output smb_pkg::smb_byte_t wr_data_o,         // Data of the last register write.
    output logic wr_stb_o,                        // One-cycle register write strobe.
    output logic rd_stb_o,                        // One-cycle register read strobe.
    output smb_pkg::smb_byte_t cfg_o,             // Device configuration register.
    output logic [6:0] own_addr_o                 // Slave address in use.
);
    import smb_pkg::*;

    logic [1:0] s1_r;
    logic [1:0] s2_r;
    logic [1:0] s3_r;
    logic [1:0] f_r;
    logic [1:0] fp_r;
    logic [2:0] st1_r;
    logic [2:0] st2_r;
    logic [2:0] st3_r;
    logic [2:0] low_r;
    logic [3:0] wait_r;
    logic taken_r;
    smb_dev_state_t state_r;
    logic [3:0] bit_r;
    logic [1:0] byte_r;
    logic [7:0] sh_r;
    logic [7:0] tx_r;
    logic rw_r;
    logic ara_r;
    logic ackph_r;
    logic ackval_r;
    logic drv_r;
    logic served_r;
    logic rd_stb_r;
    logic [7:0] ptr_r;
    logic [7:0] cfg_r;
    logic [7:0] wdat_r;
    logic wr_stb_r;
    logic scl_rise;
    logic scl_fall;
    logic start_ev;
    logic stop_ev;
    logic [7:0] rx_byte;
    logic [6:0] own_addr;
    logic int_act;
    logic me_ok;
    logic ara_ok;
    logic wr_done;
    logic ara_done;
    logic [7:0] rd_val;

    // Pins pass three flops; a level counts only once the last two agree, which also rejects short glitches.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s1_r <= 2'h3;
            s2_r <= 2'h3;
            s3_r <= 2'h3;
            f_r <= 2'h3;
            fp_r <= 2'h3;
        end else begin
            s1_r <= {bus.scl, bus.sda};
            s2_r <= s1_r;
            s3_r <= s2_r;
            f_r <= (s2_r & s3_r) | (f_r & (s2_r ^ s3_r));
            fp_r <= f_r;
        end
    end

    // Bus events from the filtered levels; bit 1 is the clock, bit 0 the data.
    assign scl_rise = f_r[1] & ~fp_r[1];
    assign scl_fall = ~f_r[1] & fp_r[1];
    assign start_ev = f_r[1] & fp_r[1] & fp_r[0] & ~f_r[0];
    assign stop_ev = f_r[1] & fp_r[1] & ~fp_r[0] & f_r[0];
    assign rx_byte = {sh_r[6:0], f_r[0]};

    // The strap is taken once, a few cycles after reset, and then frozen until the next reset.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st1_r <= 3'h0;
            st2_r <= 3'h0;
            st3_r <= 3'h0;
            low_r <= 3'h0;
            wait_r <= 4'h0;
            taken_r <= 1'h0;
        end else begin
            st1_r <= strap_i;
            st2_r <= st1_r;
            st3_r <= st2_r;
            if (!taken_r) begin
                if (wait_r != `SMB_STRAP_WAIT) begin
                    wait_r <= wait_r + 4'h1;
                end else if (st2_r == st3_r) begin
                    low_r <= st3_r;
                    taken_r <= 1'h1;
                end
            end
        end
    end

    // Address match decode; the alert address only answers a read while the interrupt is asserted.
    assign own_addr = {`SMB_ADDR_HI, low_r};
    assign int_act = fault_i & ~served_r;
    assign me_ok = rx_byte[7:1] == own_addr;
    assign ara_ok = (rx_byte[7:1] == `SMB_ARA_ADDR) & rx_byte[0] & int_act & ~cfg_r[`SMB_CFG_ARA_DIS];
    assign wr_done = (state_r == D_WR) & scl_rise & (bit_r == `SMB_LAST_BIT);
    assign ara_done = (state_r == D_TX) & scl_fall & (bit_r == `SMB_ACK_BIT) & ara_r;
    assign rd_val = (ptr_r == `SMB_CFG_OFS) ? cfg_r : rd_data_i;

    // Byte engine: shifts in on clock rise and changes the data line only after a clock fall.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_r <= D_IDLE;
            bit_r <= 4'h0;
            byte_r <= 2'h0;
            sh_r <= 8'h00;
            tx_r <= 8'h00;
            rw_r <= 1'h0;
            ara_r <= 1'h0;
            ackph_r <= 1'h0;
            ackval_r <= 1'h0;
            drv_r <= 1'h0;
            rd_stb_r <= 1'h0;
        end else begin
            rd_stb_r <= 1'h0;
            if (start_ev) begin
                state_r <= D_ADDR;
                bit_r <= 4'h0;
                byte_r <= 2'h0;
                drv_r <= 1'h0;
            end else if (stop_ev) begin
                state_r <= D_IDLE;
                drv_r <= 1'h0;
            end else begin
                case (state_r)
                    D_ADDR: begin
                        if (scl_rise) begin
                            sh_r <= rx_byte;
                            bit_r <= bit_r + 4'h1;
                            if (bit_r == `SMB_LAST_BIT) begin
                                rw_r <= rx_byte[0];
                                ara_r <= ara_ok;
                                ackph_r <= 1'h0;
                                ackval_r <= 1'h1;
                                state_r <= (me_ok | ara_ok) ? D_ACK : D_WAIT;
                            end
                        end
                    end
                    D_ACK: begin
                        if (scl_fall) begin
                            if (!ackph_r) begin
                                ackph_r <= 1'h1;
                                drv_r <= ackval_r;
                            end else begin
                                bit_r <= 4'h0;
                                if (!ackval_r) begin
                                    drv_r <= 1'h0;
                                    state_r <= D_WAIT;
                                end else if (rw_r) begin
                                    tx_r <= ara_r ? {own_addr, 1'h0} : rd_val;
                                    drv_r <= ara_r ? ~own_addr[6] : ~rd_val[7];
                                    rd_stb_r <= ~ara_r;
                                    state_r <= D_TX;
                                end else begin
                                    drv_r <= 1'h0;
                                    state_r <= D_WR;
                                end
                            end
                        end
                    end
                    D_WR: begin
                        if (scl_rise) begin
                            sh_r <= rx_byte;
                            bit_r <= bit_r + 4'h1;
                            if (bit_r == `SMB_LAST_BIT) begin
                                // A third byte is refused with a high acknowledge slot.
                                ackval_r <= byte_r != 2'h2;
                                byte_r <= (byte_r == 2'h2) ? byte_r : byte_r + 2'h1;
                                ackph_r <= 1'h0;
                                state_r <= D_ACK;
                            end
                        end
                    end
                    D_TX: begin
                        if (scl_rise) begin
                            if (ara_r & ~drv_r & ~f_r[0]) begin
                                drv_r <= 1'h0;
                                state_r <= D_WAIT;
                            end else begin
                                bit_r <= bit_r + 4'h1;
                            end
                        end else if (scl_fall) begin
                            if (bit_r == `SMB_ACK_BIT) begin
                                drv_r <= 1'h0;
                                state_r <= D_MACK;
                            end else begin
                                tx_r <= {tx_r[6:0], 1'h1};
                                drv_r <= ~tx_r[6];
                            end
                        end
                    end
                    D_MACK: begin
                        // Only one byte is ever returned, whatever the master answers.
                        if (scl_rise) begin
                            state_r <= D_WAIT;
                        end
                    end
                    D_WAIT: begin
                        drv_r <= 1'h0;
                    end
                    D_IDLE: begin
                        drv_r <= 1'h0;
                    end
                    default: begin
                        state_r <= D_IDLE;
                        drv_r <= 1'h0;
                    end
                endcase
            end
        end
    end

    // Pointer and register writes; the pointer is never cleared by a new transfer.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ptr_r <= 8'h00;
            cfg_r <= `SMB_CFG_RST;
            wdat_r <= 8'h00;
            wr_stb_r <= 1'h0;
        end else begin
            wr_stb_r <= 1'h0;
            if (wr_done && byte_r == 2'h0) begin
                ptr_r <= rx_byte;
            end else if (wr_done && byte_r == 2'h1) begin
                wdat_r <= rx_byte;
                wr_stb_r <= 1'h1;
                if (ptr_r == `SMB_CFG_OFS) begin
                    cfg_r <= rx_byte;
                end
            end
        end
    end

    // A completed alert response clears the request until the fault goes away; the set wins a tie.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            served_r <= 1'h0;
        end else if (ara_done) begin
            served_r <= 1'h1;
        end else if (!fault_i) begin
            served_r <= 1'h0;
        end
    end

    // Open-drain outputs only ever pull low.
    assign bus.dev_sda_o = 1'h0;
    assign bus.dev_sda_oe = drv_r;
    assign bus.dev_int_o = 1'h0;
    assign bus.dev_int_oe = int_act;
    assign ptr_o = ptr_r;
    assign wr_data_o = wdat_r;
    assign wr_stb_o = wr_stb_r;
    assign rd_stb_o = rd_stb_r;
    assign cfg_o = cfg_r;
    assign own_addr_o = own_addr;
endmodule : smb_dev
`default_nettype wire

// [hdl/smb_host.sv]
`timescale 1ns/10ps
`default_nettype none
`include "smb_consts.svh"
module smb_host (
    input wire logic clk_i,                       // Controller clock.
    input wire logic rstn_i,                      // Asynchronous reset, active low.
    smb_if.host bus,                              // Serial bus pins.
    input wire logic [7:0] addr_i,                // Register address.
    input wire smb_pkg::smb_byte_t wdata_i,       // Write data.
    input wire logic wr_i,                        // Write strobe.
    input wire logic rd_i,                        // Read strobe.
    output smb_pkg::smb_byte_t rdata_o            // Read data, valid the cycle after rd_i.
);
    import smb_pkg::*;

    localparam logic [7:0] QTR_LAST = 8'(`SMB_QTR_CYC - 1);
    smb_host_state_t state_r;
    logic [1:0] s1_r;
    logic [1:0] s2_r;
    logic [1:0] s3_r;
    logic [1:0] f_r;
    logic [7:0] qc_r;
    logic [1:0] q_r;
    logic [3:0] slot_r;
    logic [1:0] byte_r;
    logic [6:0] slv_r;
    logic [7:0] ptr_r;
    logic [7:0] data_r;
    logic [7:0] rx_r;
    logic [1:0] op_r;
    logic nack_r;
    logic abort_r;
    logic scl_drv_r;
    logic sda_drv_r;
    logic [7:0] rdata_r;
    logic tick;
    logic busy;
    logic rw;
    logic rx_byte;
    logic last_byte;
    logic [7:0] txb;
    logic [2:0] bi;
    logic go;

    // Bus lines come back through three flops and an agreement filter; bit 1 is the interrupt line.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s1_r <= 2'h3;
            s2_r <= 2'h3;
            s3_r <= 2'h3;
            f_r <= 2'h3;
        end else begin
            s1_r <= {bus.int_n, bus.sda};
            s2_r <= s1_r;
            s3_r <= s2_r;
            f_r <= (s2_r & s3_r) | (f_r & (s2_r ^ s3_r));
        end
    end

    // Frame decode: byte 0 is the address, then pointer and data or one byte read back.
    assign busy = state_r != H_IDLE;
    assign rw = op_r == `SMB_OP_RD;
    assign rx_byte = rw & (byte_r == 2'h1);
    assign last_byte = byte_r == ((op_r == `SMB_OP_WR) ? 2'h2 : 2'h1);
    assign txb = (byte_r == 2'h0) ? {slv_r, rw} : (byte_r == 2'h1) ? ptr_r : data_r;
    assign bi = 3'h7 - slot_r[2:0];
    assign tick = busy & (qc_r == QTR_LAST);
    assign go = wr_i & (addr_i == `SMB_H_CMD) & ~busy & (wdata_i[1:0] != 2'h0);

    // Quarter-period divider; the clock is low in quarters 0 and 1 and high in 2 and 3.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            qc_r <= 8'h00;
            q_r <= 2'h0;
        end else if (!busy) begin
            qc_r <= 8'h00;
            q_r <= 2'h0;
        end else if (tick) begin
            qc_r <= 8'h00;
            q_r <= q_r + 2'h1;
        end else begin
            qc_r <= qc_r + 8'h01;
        end
    end

    // Bit sequencer; data changes in quarter 1 so it never moves while the clock is high.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_r <= H_IDLE;
            slot_r <= 4'h0;
            byte_r <= 2'h0;
            op_r <= 2'h0;
            nack_r <= 1'h0;
            abort_r <= 1'h0;
            rx_r <= 8'h00;
            sda_drv_r <= 1'h0;
        end else begin
            case (state_r)
                H_IDLE: begin
                    sda_drv_r <= 1'h0;
                    if (go) begin
                        op_r <= wdata_i[1:0];
                        nack_r <= 1'h0;
                        abort_r <= 1'h0;
                        slot_r <= 4'h0;
                        byte_r <= 2'h0;
                        sda_drv_r <= 1'h1;
                        state_r <= H_START;
                    end
                end
                H_START: begin
                    if (tick && q_r == 2'h3) begin
                        state_r <= H_BIT;
                    end
                end
                H_BIT: begin
                    if (tick && q_r == 2'h0) begin
                        sda_drv_r <= (slot_r != `SMB_ACK_BIT) & ~rx_byte & ~txb[bi];
                    end else if (tick && q_r == 2'h2) begin
                        if (slot_r == `SMB_ACK_BIT && !rx_byte && f_r[0]) begin
                            nack_r <= 1'h1;
                            abort_r <= 1'h1;
                        end else if (slot_r != `SMB_ACK_BIT && rx_byte) begin
                            rx_r <= {rx_r[6:0], f_r[0]};
                        end
                    end else if (tick && q_r == 2'h3) begin
                        if (slot_r != `SMB_ACK_BIT) begin
                            slot_r <= slot_r + 4'h1;
                        end else if (abort_r || last_byte) begin
                            state_r <= H_STOP;
                        end else begin
                            slot_r <= 4'h0;
                            byte_r <= byte_r + 2'h1;
                        end
                    end
                end
                H_STOP: begin
                    if (tick && q_r == 2'h0) begin
                        sda_drv_r <= 1'h1;
                    end else if (tick && q_r == 2'h2) begin
                        sda_drv_r <= 1'h0;
                    end else if (tick && q_r == 2'h3) begin
                        state_r <= H_IDLE;
                    end
                end
                default: begin
                    state_r <= H_IDLE;
                end
            endcase
        end
    end

    // Clock drive; it is pulled low only in the low quarters of a bit or a stop.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            scl_drv_r <= 1'h0;
        end else begin
            scl_drv_r <= ((state_r == H_BIT) | (state_r == H_STOP)) & ~q_r[1];
        end
    end

    // Software registers; writes to the frame fields are ignored while a frame runs.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            slv_r <= 7'h00;
            ptr_r <= 8'h00;
            data_r <= 8'h00;
        end else if (wr_i && !busy) begin
            case (addr_i)
                `SMB_H_SLV: slv_r <= wdata_i[6:0];
                `SMB_H_PTR: ptr_r <= wdata_i;
                `SMB_H_DATA: data_r <= wdata_i;
                default: begin
                end
            endcase
        end
    end

    // Read port; the interrupt level lets software repeat alert reads while the line stays low.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rdata_r <= 8'h00;
        end else if (rd_i) begin
            case (addr_i)
                `SMB_H_SLV: rdata_r <= {1'h0, slv_r};
                `SMB_H_PTR: rdata_r <= ptr_r;
                `SMB_H_DATA: rdata_r <= data_r;
                `SMB_H_CMD: rdata_r <= {6'h00, op_r};
                `SMB_H_STAT: rdata_r <= {5'h00, ~f_r[1], nack_r, busy};
                `SMB_H_RX: rdata_r <= rx_r;
                default: rdata_r <= 8'h00;
            endcase
        end else begin
            rdata_r <= 8'h00;
        end
    end

    assign bus.host_scl_o = 1'h0;
    assign bus.host_scl_oe = scl_drv_r;
    assign bus.host_sda_o = 1'h0;
    assign bus.host_sda_oe = sda_drv_r;
    assign rdata_o = rdata_r;
endmodule : smb_host
`default_nettype wire

// [tb/smb_chk.sv]
`timescale 1ns/10ps
`default_nettype none
module smb_chk (
    input wire logic clk_i, // Clock.
    input wire logic rstn_i, // Reset, active low.
    input wire logic scl_i, // Resolved clock wire.
    input wire logic sda_i, // Resolved data wire.
    input wire logic sda_val_i, // Level the device drives on the data wire.
    input wire logic sda_oe_i, // Device data enable.
    input wire logic int_val_i, // Level the device drives on the interrupt wire.
    input wire logic int_oe_i // Device interrupt enable.
);
    // One clock domain, so clock and reset are given once for every check.
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    property p_scl_hi; $rose(scl_i) |-> scl_i[*8]; endproperty
    a_scl_hi: assert property (p_scl_hi) else $error("short clock high");
    property p_scl_lo; $fell(scl_i) |-> (!scl_i)[*8]; endproperty
    a_scl_lo: assert property (p_scl_lo) else $error("short clock low");
    property p_stbl; scl_i && $past(scl_i) |-> $stable(sda_oe_i); endproperty
    a_stbl: assert property (p_stbl) else $error("data moved in clock high");
    property p_od; sda_oe_i |-> !sda_val_i; endproperty
    a_od: assert property (p_od) else $error("data drive not low");
    property p_hold; $rose(sda_oe_i) |-> sda_oe_i[*8]; endproperty
    a_hold: assert property (p_hold) else $error("drive too short");
    property p_int; int_oe_i |-> !int_val_i; endproperty
    a_int: assert property (p_int) else $error("interrupt drive not low");
    property p_start; scl_i && $fell(sda_i) |=> (!sda_oe_i)[*8]; endproperty
    a_start: assert property (p_start) else $error("drive right after start");
    property p_stop; scl_i && $rose(sda_i) |=> (!sda_oe_i)[*8]; endproperty
    a_stop: assert property (p_stop) else $error("drive after stop");
endmodule : smb_chk
`default_nettype wire

// [tb/test_smbus_slave_pointer_ara.sv]
`timescale 1ns/10ps
`default_nettype none
`include "smb_consts.svh"
module test_smbus_slave_pointer_ara;
    localparam logic [6:0] me = {`SMB_ADDR_HI, 3'h7};
    logic clk, rstn, wr, rd, fault;
    logic [2:0] strap;
    logic [7:0] addr, wdata, rdata, v, ptr, wdat, cfg;
    logic [6:0] own;
    logic wstb, rstb;
    int checked, miscompares;
    int wr_cnt = 0;
    int rd_cnt = 0;
    smb_if u_bus();
    smb_host u_smb_host(.clk_i(clk), .rstn_i(rstn), .bus(u_bus), .addr_i(addr), .wdata_i(wdata),
        .wr_i(wr), .rd_i(rd), .rdata_o(rdata));
    smb_dev u_smb_dev(.clk_i(clk), .rstn_i(rstn), .bus(u_bus), .strap_i(strap), .fault_i(fault),
        .rd_data_i(ptr ^ 8'h3c), .ptr_o(ptr), .wr_data_o(wdat), .wr_stb_o(wstb), .rd_stb_o(rstb), .cfg_o(cfg),
        .own_addr_o(own));
    smb_chk u_smb_chk(.clk_i(clk), .rstn_i(rstn), .scl_i(u_bus.scl), .sda_i(u_bus.sda),
        .sda_val_i(u_bus.dev_sda_o), .sda_oe_i(u_bus.dev_sda_oe), .int_val_i(u_bus.dev_int_o),
        .int_oe_i(u_bus.dev_int_oe));
    // Free-running 10 MHz clock.
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // Counts register strobes so that writes and reads behind the pointer are seen, not just the bus.
    always @(posedge clk) begin
        if (wstb === 1'b1) begin
            wr_cnt <= wr_cnt + 1;
        end
        if (rstb === 1'b1) begin
            rd_cnt <= rd_cnt + 1;
        end
    end
    task automatic print_verdict;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : print_verdict
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        checked++;
        if (g !== e) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    // Software port cycles; read data is taken in the cycle after the strobe.
    task automatic put(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : put
    task automatic get(input logic [7:0] a);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask : get
    // Runs one host command and leaves its status in v; the tail wait covers the bus free time.
    task automatic xfer(input logic [6:0] s, input logic [7:0] p, input logic [7:0] d, input logic [1:0] op);
        put(`SMB_H_SLV, {1'b0, s});
        put(`SMB_H_PTR, p);
        put(`SMB_H_DATA, d);
        put(`SMB_H_CMD, {6'h00, op});
        v = 8'h01;
        for (int i = 0; i < 3000 && v[0] === 1'b1; i++) get(`SMB_H_STAT);
        chk("busy", 8'h00, {7'h00, v[0]});
        if (v[0] !== 1'b0) begin
            print_verdict();
        end
        repeat (60) @(posedge clk);
    endtask : xfer
    // Every reset is a fresh power-up, so each strap code gets its own capture.
    task automatic t_addr;
        for (int k = 0; k < 8; k++) begin
            rstn <= 1'b0;
            strap <= k[2:0];
            repeat (2) @(posedge clk);
            rstn <= 1'b1;
            repeat (30) @(posedge clk);
            strap <= ~k[2:0];
            repeat (30) @(posedge clk);
            chk("own", {1'b0, `SMB_ADDR_HI, k[2:0]}, {1'b0, own});
        end
        $display("address test done");
    endtask : t_addr
    task automatic t_xfer;
        xfer(me, 8'h22, 8'ha5, `SMB_OP_WR);
        chk("nack", 8'h00, v & 8'h02);
        chk("ptr", 8'h22, ptr);
        chk("wdata", 8'ha5, wdat);
        chk("wstb", 8'h01, wr_cnt[7:0]);
        get(`SMB_H_SLV);
        chk("slv", {1'b0, me}, v);
        get(`SMB_H_CMD);
        chk("cmd", {6'h00, `SMB_OP_WR}, v);
        xfer(me, 8'h37, 8'h00, `SMB_OP_PTR);
        chk("ptr", 8'h37, ptr);
        chk("wstb", 8'h01, wr_cnt[7:0]);
        xfer(me, 8'h00, 8'h00, `SMB_OP_RD);
        chk("rstb", 8'h01, rd_cnt[7:0]);
        get(`SMB_H_RX);
        chk("rx", 8'h37 ^ 8'h3c, v);
        xfer(me ^ 7'h01, 8'h11, 8'h00, `SMB_OP_WR);
        chk("nack", 8'h02, v & 8'h02);
        chk("ptr", 8'h37, ptr);
        $display("transfer test done");
    endtask : t_xfer
    task automatic t_ara;
        fault <= 1'b1;
        repeat (2) @(posedge clk);
        chk("int", 8'h00, {7'h00, u_bus.int_n});
        xfer(`SMB_ARA_ADDR, 8'h00, 8'h00, `SMB_OP_RD);
        get(`SMB_H_RX);
        chk("ara", {me, 1'b0}, v);
        chk("int", 8'h01, {7'h00, u_bus.int_n});
        get(`SMB_H_STAT);
        chk("int_stat", 8'h00, v & 8'h04);
        fault <= 1'b0;
        xfer(me, `SMB_CFG_OFS, 8'h04, `SMB_OP_WR);
        chk("cfg", 8'h04, cfg);
        chk("wstb", 8'h02, wr_cnt[7:0]);
        fault <= 1'b1;
        xfer(`SMB_ARA_ADDR, 8'h00, 8'h00, `SMB_OP_RD);
        chk("nack", 8'h02, v & 8'h02);
        chk("int", 8'h00, {7'h00, u_bus.int_n});
        get(`SMB_H_STAT);
        chk("int_stat", 8'h04, v & 8'h04);
        chk("rstb", 8'h01, rd_cnt[7:0]);
        $display("alert test done");
    endtask : t_ara
    // Reset is held by the first pass of the address test.
    initial begin
        rstn = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        fault = 1'b0;
        strap = 3'h0;
        addr = 8'h00;
        wdata = 8'h00;
        checked = 0;
        miscompares = 0;
        t_addr();
        t_xfer();
        t_ara();
        print_verdict();
    end
endmodule : test_smbus_slave_pointer_ara
`default_nettype wire
